/* File: dsp_defs.svh */
// constants of the strobe phase-shift dll: widths, limits, counts, codes
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH

// ----------------------------------------------------------------
// setting and offset widths and limits
// ----------------------------------------------------------------
`define DSP_SET_W        6
`define DSP_OFF_W        7
`define DSP_MAX_WIDE     6'h3f
`define DSP_MAX_NARROW   6'h1f
`define DSP_OFF_MIN_WIDE   7'h40
`define DSP_OFF_MAX_WIDE   7'h3f
`define DSP_OFF_MIN_NARROW 7'h60
`define DSP_OFF_MAX_NARROW 7'h1f

// ----------------------------------------------------------------
// frequency modes and delay chain lengths
// ----------------------------------------------------------------
`define DSP_MODE_W          3
`define DSP_MODE_FIRST_NARROW 3'h4
`define DSP_MODE_LAST       3'h6
`define DSP_ELEMS_M0        5'h10
`define DSP_ELEMS_M1        5'h0c
`define DSP_ELEMS_M2        5'h0a
`define DSP_ELEMS_M3        5'h08
`define DSP_STROBE_ELEMS    3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DSP_LOCK_CYCLES     11'h500
`define DSP_CLK_PERIOD_NS   20
`define DSP_UPD_PERIOD_NS   160
`define DSP_UPD_CYCLES      (`DSP_UPD_PERIOD_NS / `DSP_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// per-strobe setting sources
// ----------------------------------------------------------------
`define DSP_SRC_NEAR_DLL    2'h0
`define DSP_SRC_FAR_DLL     2'h1
`define DSP_SRC_CORE        2'h2

`endif

/* File: dsp_pkg.sv */
// types and coding helpers of the strobe phase-shift dll
package dsp_pkg;
  `include "dsp_defs.svh"

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [`DSP_SET_W-1:0]  dsp_set_t;
  typedef logic [`DSP_OFF_W-1:0]  dsp_off_t;
  typedef logic [`DSP_MODE_W-1:0] dsp_mode_t;

  typedef enum logic [1:0] {DSP_ST_RESET, DSP_ST_ACQUIRE, DSP_ST_LOCKED}
    dsp_state_t;

  // one offset unit: static value or per-cycle magnitude with direction
  typedef struct packed {
    logic     dynamic;
    logic     addNotSub;
    dsp_set_t magnitude;
    dsp_off_t staticOffs;
  } dsp_offs_cfg_t;

  // one per-strobe delay chain
  typedef struct packed {
    logic       bypass;
    logic [1:0] source;
    logic       useOffset;
    logic       sideLr;
    logic [1:0] extraElems;
  } dsp_chain_cfg_t;

  // ----------------------------------------------------------------
  // coding helpers
  // ----------------------------------------------------------------
  function automatic dsp_off_t dsp_bin2gray(input dsp_off_t b);
    return b ^ (b >> 1);
  endfunction : dsp_bin2gray

  function automatic dsp_off_t dsp_gray2bin(input dsp_off_t g);
    dsp_off_t b;
    b[`DSP_OFF_W-1] = g[`DSP_OFF_W-1];
    for (int i = `DSP_OFF_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : dsp_gray2bin

  function automatic logic dsp_narrow(input dsp_mode_t m);
    return m >= `DSP_MODE_FIRST_NARROW;
  endfunction : dsp_narrow

  function automatic dsp_set_t dsp_max_set(input dsp_mode_t m);
    return dsp_narrow(m) ? `DSP_MAX_NARROW : `DSP_MAX_WIDE;
  endfunction : dsp_max_set

  // dll setting plus signed offset, held inside the mode's range
  function automatic dsp_set_t dsp_sum(input dsp_set_t s, input dsp_off_t o,
                                       input dsp_mode_t m);
    logic signed [7:0] t;
    t = $signed({2'b00, s}) + $signed({o[`DSP_OFF_W-1], o});
    if (t < 0) begin
      return '0;
    end else if (t > $signed({2'b00, dsp_max_set(m)})) begin
      return dsp_max_set(m);
    end else begin
      return t[`DSP_SET_W-1:0];
    end
  endfunction : dsp_sum
endpackage : dsp_pkg

/* File: dsp_strobe_chain.sv */
// per-strobe delay chain: source choice, offset sum, update register
`timescale 1ns/1ps
`include "dsp_defs.svh"
module dsp_strobe_chain
  import dsp_pkg::*;
#(
  parameter int INTRINSIC_PS = 50,
  parameter int STEP_PS      = 10
) (
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire dsp_chain_cfg_t cfg,
  input  wire dsp_mode_t      freqMode,
  input  wire logic           updEn,
  input  wire dsp_set_t       nearSetG,
  input  wire dsp_set_t       farSetG,
  input  wire dsp_set_t       coreSetG,
  input  wire dsp_off_t       offsG,
  input  wire logic           strobeIn,
  input  wire logic           cqnIn,
  input  wire logic           resyncUnused,
  input  wire logic           qdrMode,
  output logic                strobeBus,
  output logic                strobeCore,
  output logic                cqnNegStrobe,
  output dsp_set_t            firstSet,
  output logic [8:0]          totalSteps,
  output logic [15:0]         totalDelay
);
  dsp_set_t    srcSet;
  dsp_set_t    firstSet_d;
  dsp_set_t    firstSet_q;
  logic [8:0]  steps_d;
  logic [8:0]  steps_q;
  logic [15:0] delay_d;
  logic [15:0] delay_q;
  logic [2:0]  nElems;

  // ----------------------------------------------------------------
  // setting selection and delay sum
  // ----------------------------------------------------------------
  always_comb begin
    case (cfg.source)
      `DSP_SRC_NEAR_DLL: srcSet = dsp_set_t'(
                                  dsp_gray2bin({1'b0, nearSetG}));
      `DSP_SRC_FAR_DLL:  srcSet = dsp_set_t'(
                                  dsp_gray2bin({1'b0, farSetG}));
      default:           srcSet = dsp_set_t'(
                                  dsp_gray2bin({1'b0, coreSetG}));
    endcase
    if (dsp_narrow(freqMode)) begin
      srcSet[`DSP_SET_W-1] = 1'b0;
    end
    // element nearest the pin may carry the offset sum
    firstSet_d = cfg.useOffset ?
                 dsp_sum(srcSet, dsp_gray2bin(offsG), freqMode) : srcSet;
    nElems  = 3'(cfg.extraElems) + 3'h1;
    steps_d = 9'(firstSet_d) + 9'(srcSet) * 9'(cfg.extraElems);
    delay_d = 16'(nElems) * 16'(INTRINSIC_PS)
            + 16'(steps_d) * 16'(STEP_PS);
    // zero degree shift: strobe skips the chain, no delay at all
    if (cfg.bypass) begin
      steps_d = '0;
      delay_d = '0;
    end
    if (!updEn) begin
      firstSet_d = firstSet_q;
      steps_d    = steps_q;
      delay_d    = delay_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      firstSet_q <= '0;
      steps_q    <= '0;
      delay_q    <= '0;
    end else begin
      firstSet_q <= firstSet_d;
      steps_q    <= steps_d;
      delay_q    <= delay_d;
    end
  end

  assign firstSet   = firstSet_q;
  assign totalSteps = steps_q;
  assign totalDelay = delay_q;

  // ----------------------------------------------------------------
  // strobe routing; the delay itself is in the analog elements
  // ----------------------------------------------------------------
  assign strobeBus    = strobeIn;
  assign strobeCore   = resyncUnused & strobeIn;
  assign cqnNegStrobe = qdrMode & cqnIn;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  upd_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !updEn |=> $stable(firstSet_q) && $stable(delay_q))
    else $error("chain setting changed without update enable");

  cqn_only_qdr_a: assert property (@(posedge clk) disable iff (!nrst)
    !qdrMode |-> !cqnNegStrobe)
    else $error("cqn strobe driven outside qdr mode");

  narrow_first_a: assert property (@(posedge clk) disable iff (!nrst)
    dsp_narrow(freqMode) && $past(dsp_narrow(freqMode)) && $past(updEn)
    |-> firstSet_q <= `DSP_MAX_NARROW)
    else $error("narrow mode chain setting above its limit");

  bypass_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    cfg.bypass && updEn |=> totalDelay == '0 && totalSteps == '0)
    else $error("bypassed strobe chain still reports a delay");
endmodule : dsp_strobe_chain

/* File: dsp_dll_top.sv */
// strobe phase-shift dll: tracking loop, offset units, one strobe chain
`timescale 1ns/1ps
`include "dsp_defs.svh"
// How it works
// - comparator steers six-bit gray up/down counter
// - reference drives up to sixteen delay elements
// - dll reset from core or pin
// - seven modes, 6-bit or 5-bit settings
// - narrow modes hold setting msb at zero
// - zero degree shift bypasses the strobe chain
// - shifted strobe clocks inputs, optionally core
// - cqn strobe feeds negative-edge register only
// - two offset units, top/bottom and left/right
// - offsets gray two's complement, mode range
// - setting plus offset clamped to mode limit
// - dll settings leave in gray code
// - offset static or dynamic per cycle
// - one to four elements, first may take offset sum
// - chain setting from either dll or core
// - delay is intrinsic plus steps times step
// - settings to core; offsets to chains only
// - reference from pll clock or pin
// - settings registered under update enable
module dsp_dll_top
  import dsp_pkg::*;
#(
  parameter int INTRINSIC_PS = 50,
  parameter int STEP_PS      = 10
) (
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           pllRefClk,
  input  wire logic           pinRefClk,
  input  wire logic           refFromPin,
  input  wire logic           coreDllReset,
  input  wire logic           pinDllReset,
  input  wire logic           chainFeedback,
  input  wire dsp_mode_t      freqMode,
  input  wire dsp_offs_cfg_t  offsTbCfg,
  input  wire dsp_offs_cfg_t  offsLrCfg,
  input  wire dsp_chain_cfg_t chainCfg,
  input  wire dsp_set_t       farDllSetG,
  input  wire dsp_set_t       coreSetG,
  input  wire logic           strobeIn,
  input  wire logic           cqnIn,
  input  wire logic           resyncUnused,
  input  wire logic           qdrMode,
  output dsp_set_t            dllSetG,
  output logic                dllLocked,
  output logic [4:0]          dllChainElems,
  output logic                strobeBus,
  output logic                strobeCore,
  output logic                cqnNegStrobe,
  output dsp_set_t            firstSet,
  output logic [8:0]          totalSteps,
  output logic [15:0]         totalDelay
);
  // ----------------------------------------------------------------
  // reference clock choice
  // ----------------------------------------------------------------
  logic refClk;
  assign refClk = refFromPin ? pinRefClk : pllRefClk;

  // ----------------------------------------------------------------
  // reference domain: synchronisers
  // ----------------------------------------------------------------
  logic      rstMeta_q;
  logic      rstReq_q;
  logic      fbMeta_q;
  logic      fbSync_q;
  dsp_mode_t modeMeta_q;
  dsp_mode_t modeRef_q;

  // reset request from core or pin, feedback and mode, two flops each
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q  <= 1'b1;
      rstReq_q   <= 1'b1;
      fbMeta_q   <= 1'b0;
      fbSync_q   <= 1'b0;
      modeMeta_q <= '0;
      modeRef_q  <= '0;
    end else begin
      rstMeta_q  <= coreDllReset | pinDllReset;
      rstReq_q   <= rstMeta_q;
      fbMeta_q   <= chainFeedback;
      fbSync_q   <= fbMeta_q;
      modeMeta_q <= freqMode;
      modeRef_q  <= modeMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // reference domain: tracking counter and lock timer
  // ----------------------------------------------------------------
  dsp_state_t  state_d;
  dsp_state_t  state_q;
  dsp_set_t    setB_d;
  dsp_set_t    setB_q;
  dsp_set_t    setG_q;
  logic [10:0] lockCnt_d;
  logic [10:0] lockCnt_q;
  logic        countUp;
  dsp_set_t    maxRef;
  logic        lockRef_q;

  // late feedback counts down, early feedback counts up
  always_comb begin
    countUp   = !fbSync_q;
    maxRef    = dsp_max_set(modeRef_q);
    setB_d    = setB_q;
    state_d   = state_q;
    lockCnt_d = lockCnt_q;
    if (setB_q > maxRef) begin
      setB_d = maxRef;
    end else if (countUp && setB_q != maxRef) begin
      setB_d = setB_q + 6'h01;
    end else if (!countUp && setB_q != '0) begin
      setB_d = setB_q - 6'h01;
    end
    case (state_q)
      DSP_ST_RESET: begin
        state_d   = DSP_ST_ACQUIRE;
        lockCnt_d = '0;
      end
      DSP_ST_ACQUIRE: begin
        lockCnt_d = lockCnt_q + 11'h001;
        if (lockCnt_d == `DSP_LOCK_CYCLES) begin
          state_d = DSP_ST_LOCKED;
        end
      end
      DSP_ST_LOCKED: begin
        state_d = DSP_ST_LOCKED;
      end
      default: begin
        state_d = DSP_ST_RESET;
      end
    endcase
    if (rstReq_q) begin
      setB_d    = '0;
      state_d   = DSP_ST_RESET;
      lockCnt_d = '0;
    end
  end

  // gray copy registered directly so the crossing sees one bit move
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= DSP_ST_RESET;
      setB_q    <= '0;
      setG_q    <= '0;
      lockCnt_q <= '0;
      lockRef_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      setB_q    <= setB_d;
      setG_q    <= dsp_set_t'(dsp_bin2gray({1'b0, setB_d}));
      lockCnt_q <= lockCnt_d;
      lockRef_q <= (state_d == DSP_ST_LOCKED);
    end
  end

  // ----------------------------------------------------------------
  // system clock domain: settings and lock status crossing
  // ----------------------------------------------------------------
  dsp_set_t setMeta_q;
  dsp_set_t setSync_q;
  logic     lockMeta_q;
  logic     lockSync_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      setMeta_q  <= '0;
      setSync_q  <= '0;
      lockMeta_q <= 1'b0;
      lockSync_q <= 1'b0;
    end else begin
      setMeta_q  <= setG_q;
      setSync_q  <= setMeta_q;
      lockMeta_q <= lockRef_q;
      lockSync_q <= lockMeta_q;
    end
  end

  assign dllLocked = lockSync_q;

  // chain length in use for this mode
  always_comb begin
    case (freqMode)
      3'h0:    dllChainElems = `DSP_ELEMS_M0;
      3'h1:    dllChainElems = `DSP_ELEMS_M1;
      3'h4:    dllChainElems = `DSP_ELEMS_M1;
      3'h2:    dllChainElems = `DSP_ELEMS_M2;
      3'h5:    dllChainElems = `DSP_ELEMS_M2;
      default: dllChainElems = `DSP_ELEMS_M3;
    endcase
  end

  // ----------------------------------------------------------------
  // offset units and update enable
  // ----------------------------------------------------------------
  dsp_set_t   dllReg_q;
  dsp_set_t   dllReg_d;
  dsp_off_t   offsTbG_q;
  dsp_off_t   offsTbG_d;
  dsp_off_t   offsLrG_q;
  dsp_off_t   offsLrG_d;
  logic [3:0] updCnt_q;
  logic [3:0] updCnt_d;
  logic       updEn;
  assign dllSetG   = dllReg_q;

  // static value or dynamic magnitude, clamped to the mode's range
  function automatic dsp_off_t offs_value(input dsp_offs_cfg_t c,
                                          input dsp_mode_t m);
    dsp_off_t v;
    dsp_off_t lo;
    dsp_off_t hi;
    lo = dsp_narrow(m) ? `DSP_OFF_MIN_NARROW : `DSP_OFF_MIN_WIDE;
    hi = dsp_narrow(m) ? `DSP_OFF_MAX_NARROW : `DSP_OFF_MAX_WIDE;
    if (!c.dynamic) begin
      v = c.staticOffs;
    end else if (c.addNotSub) begin
      v = {1'b0, c.magnitude};
    end else begin
      v = 7'h00 - {1'b0, c.magnitude};
    end
    if (!c.dynamic || !c.addNotSub) begin
      if ($signed(v) < $signed(lo)) begin
        v = lo;
      end
    end
    if ($signed(v) > $signed(hi)) begin
      v = hi;
    end
    return v;
  endfunction : offs_value

  always_comb begin
    updEn     = (updCnt_q == 4'h0);
    updCnt_d  = updEn ? 4'(`DSP_UPD_CYCLES - 1) : updCnt_q - 4'h1;
    dllReg_d  = dllReg_q;
    offsTbG_d = offsTbG_q;
    offsLrG_d = offsLrG_q;
    if (updEn) begin
      dllReg_d  = setSync_q;
      if (dsp_narrow(freqMode)) begin
        dllReg_d[`DSP_SET_W-1] = 1'b0;
      end
      offsTbG_d = dsp_bin2gray(offs_value(offsTbCfg, freqMode));
      offsLrG_d = dsp_bin2gray(offs_value(offsLrCfg, freqMode));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      updCnt_q  <= '0;
      dllReg_q  <= '0;
      offsTbG_q <= '0;
      offsLrG_q <= '0;
    end else begin
      updCnt_q  <= updCnt_d;
      dllReg_q  <= dllReg_d;
      offsTbG_q <= offsTbG_d;
      offsLrG_q <= offsLrG_d;
    end
  end

  // ----------------------------------------------------------------
  // per-strobe chain; offsets reach only this block
  // ----------------------------------------------------------------
  dsp_strobe_chain #(
    .INTRINSIC_PS (INTRINSIC_PS),
    .STEP_PS      (STEP_PS)
  ) u_chain (
    .clk          (clk),
    .nrst         (nrst),
    .cfg          (chainCfg),
    .freqMode     (freqMode),
    .updEn        (updEn),
    .nearSetG     (dllReg_q),
    .farSetG      (farDllSetG),
    .coreSetG     (coreSetG),
    .offsG        (chainCfg.sideLr ? offsLrG_q : offsTbG_q),
    .strobeIn     (strobeIn),
    .cqnIn        (cqnIn),
    .resyncUnused (resyncUnused),
    .qdrMode      (qdrMode),
    .strobeBus    (strobeBus),
    .strobeCore   (strobeCore),
    .cqnNegStrobe (cqnNegStrobe),
    .firstSet     (firstSet),
    .totalSteps   (totalSteps),
    .totalDelay   (totalDelay)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence reset_seen_s;
    rstReq_q ##1 !rstReq_q;
  endsequence

  reset_clears_a: assert property (@(posedge refClk) disable iff (!nrst)
    reset_seen_s |-> setB_q == '0 && state_q == DSP_ST_RESET)
    else $error("dll reset did not clear the counter");
  lock_wait_a: assert property (@(posedge refClk) disable iff (!nrst)
    state_q == DSP_ST_LOCKED && $past(state_q) != DSP_ST_LOCKED
    |-> $past(lockCnt_q) == `DSP_LOCK_CYCLES - 11'h001)
    else $error("lock declared before the wait elapsed");
  step_one_a: assert property (@(posedge refClk) disable iff (!nrst)
    !rstReq_q && !$past(rstReq_q) && $past(setB_q) <= dsp_max_set(modeRef_q)
    && $stable(modeRef_q)
    |-> setB_q == $past(setB_q) + 6'h01 || setB_q == $past(setB_q) - 6'h01
        || setB_q == $past(setB_q))
    else $error("dll setting moved by more than one step");
  sat_top_a: assert property (@(posedge refClk) disable iff (!nrst)
    setB_q == dsp_max_set(modeRef_q) && !fbSync_q && !rstReq_q
    && $stable(modeRef_q) |=> setB_q == $past(setB_q))
    else $error("dll setting wrapped past its maximum");
  gray_one_a: assert property (@(posedge refClk) disable iff (!nrst)
    !$past(rstReq_q) |-> $countones(setG_q ^ $past(setG_q)) <= 1)
    else $error("gray setting changed more than one bit");
  narrow_msb_a: assert property (@(posedge clk) disable iff (!nrst)
    dsp_narrow(freqMode) && $past(updEn) && $stable(freqMode)
    |-> !dllReg_q[`DSP_SET_W-1])
    else $error("narrow mode setting msb not zero");
  offs_range_a: assert property (@(posedge clk) disable iff (!nrst)
    dsp_narrow(freqMode) && $past(updEn) && $stable(freqMode)
    |-> $signed(dsp_gray2bin(offsTbG_q)) <= $signed(`DSP_OFF_MAX_NARROW)
     && $signed(dsp_gray2bin(offsTbG_q)) >= $signed(`DSP_OFF_MIN_NARROW))
    else $error("offset outside the narrow mode range");
  bypass_path_a: assert property (@(posedge clk) disable iff (!nrst)
    chainCfg.bypass |-> strobeBus == strobeIn)
    else $error("bypassed strobe not passed straight through");
endmodule : dsp_dll_top

/* File: dsp_core_model.sv */
// partner model: reference clock and delay-chain feedback
`timescale 1ns/1ps
module dsp_core_model
  import dsp_pkg::*;
#(
  parameter int TARGET = 64
) (
  input  wire dsp_set_t dllSetG,
  output logic          refClk,
  output logic          chainFeedback
);
  logic [5:0] setB;

  // reference clock, 80 ns, phase unrelated to clk
  initial begin
    refClk = 1'b0;
    #7;
    forever #40 refClk = ~refClk;
  end

  // decode the gray setting and report early or late
  always_comb begin
    setB[5] = dllSetG[5];
    for (int i = 4; i >= 0; i--) begin
      setB[i] = setB[i+1] ^ dllSetG[i];
    end
    chainFeedback = (int'(setB) >= TARGET);
  end
endmodule : dsp_core_model

/* File: dsp_dll_top_tb.sv */
// self-checking bench of the strobe phase-shift dll
`timescale 1ns/1ps
module dsp_dll_top_tb;
  import dsp_pkg::*;
  logic           clk = 1'b0, nrst = 1'b0, refClk, fb;
  logic           strobeIn = 1'b0, cqnIn = 1'b0, resyncUnused = 1'b0;
  logic           qdrMode = 1'b0, coreDllReset = 1'b0, pinDllReset = 1'b0;
  logic           sBus, sCore, cqnNeg, locked;
  dsp_mode_t      freqMode = 3'h0;
  dsp_offs_cfg_t  tbCfg = '0, lrCfg = '0;
  dsp_chain_cfg_t chainCfg = '0;
  dsp_set_t       coreSetG = 6'h00, dllSetG, firstSet;
  logic [4:0]     elems;
  logic [8:0]     steps;
  logic [15:0]    dly;
  int             bad_count = 0, check_count = 0, cyc = 0, relCyc = 0;

  dsp_core_model model (.dllSetG(dllSetG), .refClk(refClk),
    .chainFeedback(fb));
  dsp_dll_top dut (.clk(clk), .nrst(nrst), .pllRefClk(refClk),
    .pinRefClk(refClk), .refFromPin(1'b0), .coreDllReset(coreDllReset),
    .pinDllReset(pinDllReset), .chainFeedback(fb), .freqMode(freqMode),
    .offsTbCfg(tbCfg), .offsLrCfg(lrCfg), .chainCfg(chainCfg),
    .farDllSetG(6'h00), .coreSetG(coreSetG), .strobeIn(strobeIn),
    .cqnIn(cqnIn), .resyncUnused(resyncUnused), .qdrMode(qdrMode),
    .dllSetG(dllSetG), .dllLocked(locked), .dllChainElems(elems),
    .strobeBus(sBus), .strobeCore(sCore), .cqnNegStrobe(cqnNeg),
    .firstSet(firstSet), .totalSteps(steps), .totalDelay(dly));

  // system clock, 20 ns
  always #10 clk = ~clk;

  // cycle count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic t_modes;
    logic [4:0] ex [7] = '{5'h10, 5'h0c, 5'h0a, 5'h08, 5'h0c, 5'h0a, 5'h08};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      freqMode <= 3'(i);
      @(posedge clk);
      #1;
      chk("chain elements", elems, ex[i]);
    end
    @(posedge clk);
    freqMode <= 3'h0;
    $display("test modes done");
  endtask : t_modes

  task automatic t_lock;
    int dt;
    while (locked !== 1'b1 && cyc < relCyc + 6000) begin
      @(posedge clk);
      #1;
    end
    dt = cyc - relCyc;
    chk("lock time", 16'(dt >= 5120 && dt <= 5170), 1);
    chk("setting at top", dllSetG, 16'h20);
    $display("test lock done");
  endtask : t_lock

  task automatic t_route;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      {chainCfg.bypass, strobeIn, cqnIn, resyncUnused, qdrMode} <= 5'(i);
      #1;
      chk("strobe routing", {sBus, sCore, cqnNeg},
        {strobeIn, strobeIn & resyncUnused, cqnIn & qdrMode});
    end
    wt(24);
    #1;
    chk("bypass delay", dly, 16'h0);
    $display("test routing done");
  endtask : t_route

  task automatic t_core;
    for (int e = 0; e < 4; e++) begin
      @(posedge clk);
      chainCfg <= '{1'b0, 2'h2, 1'b0, 1'b0, 2'(e)};
      coreSetG <= 6'h20;
      wt(24);
      #1;
      chk("first setting", firstSet, 16'd63);
      chk("total steps", steps, 16'(63 + 63 * e));
      chk("total delay", dly, 16'((e + 1) * 50 + (63 + 63 * e) * 10));
    end
    @(posedge clk);
    chainCfg <= '{1'b0, 2'h1, 1'b0, 1'b0, 2'h0};
    wt(24);
    #1;
    chk("far setting", firstSet, 16'h0);
    $display("test core setting done");
  endtask : t_core

  task automatic t_offs(input int hi, lo);
    @(posedge clk);
    lrCfg <= '{1'b0, 1'b0, 6'h00, 7'h01};
    tbCfg <= '{1'b1, 1'b0, 6'h01, 7'h00};
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk);
      chainCfg <= '{1'b0, 2'h0, 1'b1, 1'(s), 2'h0};
      wt(24);
      #1;
      chk("offset sum", firstSet, 16'(s ? hi : lo));
    end
    $display("test offsets done");
  endtask : t_offs

  task automatic t_rst(input logic pin);
    @(posedge clk);
    if (pin) pinDllReset <= 1'b1;
    else coreDllReset <= 1'b1;
    wt(40);
    #1;
    chk("reset setting", dllSetG, 16'h0);
    chk("reset lock", locked, 16'h0);
    @(posedge clk);
    {coreDllReset, pinDllReset} <= 2'b00;
    freqMode <= 3'h4;
    $display("test dll reset done");
  endtask : t_rst

  // main sequence
  initial begin
    wt(4);
    #1;
    chk("idle setting", dllSetG, 16'h0);
    wt(1);
    nrst <= 1'b1;
    relCyc = cyc;
    t_modes();
    t_lock();
    t_route();
    t_core();
    t_offs(63, 62);
    t_rst(1'b0);
    wt(500);
    #1;
    chk("narrow top", dllSetG, 16'h10);
    t_offs(31, 30);
    t_rst(1'b1);
    print_verdict();
  end
endmodule : dsp_dll_top_tb
